// ==== core/adc_regs_pkg.sv ====
package adc_regs_pkg;

   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int NUM_CH = 4;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_IDENT        = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS       = 6'h01;
   localparam logic [ADDR_W-1:0] OFF_MODE         = 6'h02;
   localparam logic [ADDR_W-1:0] OFF_CH2_GAIN_HI  = 6'h16;
   localparam logic [ADDR_W-1:0] OFF_CH2_GAIN_LO  = 6'h17;
   localparam logic [ADDR_W-1:0] OFF_CH3_INPUT_CONFIG      = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_CH3_OFS_HI   = 6'h19;
   localparam logic [ADDR_W-1:0] OFF_CH3_OFS_LO   = 6'h1A;
   localparam logic [ADDR_W-1:0] OFF_CH3_GAIN_HI  = 6'h1B;
   localparam logic [ADDR_W-1:0] OFF_CH3_GAIN_LO  = 6'h1C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS   = 6'h20;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR    = 6'h21;
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE   = 6'h22;
   localparam logic [ADDR_W-1:0] OFF_MAP_CHECKSUM = 6'h3E;
   localparam logic [ADDR_W-1:0] OFF_SPARE        = 6'h3F;

   // Identity fields
   localparam logic [3:0] IDENT_TOP_NIBBLE    = 4'h4;
   localparam logic [3:0] CHANNEL_COUNT_FIELD = 4'h4;

   // Status and mode field positions
   localparam int BIT_LOCK       = 15;
   localparam int BIT_REALIGN    = 14;
   localparam int BIT_MAP_FAULT  = 13;
   localparam int BIT_RX_CRC_ERR = 12;
   localparam int BIT_CRC_TYPE   = 11;
   localparam int BIT_RESET_FLAG = 10;
   localparam int WSIZE_MSB      = 9;
   localparam int WSIZE_LSB      = 8;

   localparam logic [DATA_W-1:0] MODE_RST   = 16'h0510;
   localparam logic [DATA_W-1:0] STATUS_RST = 16'h0500;

   // Interrupt bit layout
   localparam int IRQ_W         = 7;
   localparam int IRQ_REALIGN   = 0;
   localparam int IRQ_MAP_FAULT = 1;
   localparam int IRQ_RX_CRC    = 2;
   localparam int IRQ_READY_LSB = 3;

   // Trim store: index = offset - OFF_CH2_GAIN_HI
   localparam int TRIM_DEPTH = 8;
   localparam int TRIM_IDX_W = 3;
   localparam logic [TRIM_DEPTH-1:0][DATA_W-1:0] TRIM_RST = {
      16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
   localparam logic [TRIM_DEPTH-1:0][DATA_W-1:0] TRIM_WR_MASK = {
      16'h0000, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'h0003, 16'hFF00, 16'hFFFF};

endpackage

// ==== core/trim_mem_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface trim_mem_if;
   logic        wr;
   logic        rd;
   logic [2:0]  idx;
   logic [15:0] wdata;
   logic [15:0] rdata;

   modport ctrl  (output wr, output rd, output idx, output wdata, input rdata);
   modport store (input wr, input rd, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== core/trim_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module trim_mem (
   input  wire logic  clk,
   input  wire logic  rst,
   trim_mem_if.store  bus
);
   import adc_regs_pkg::*;

   typedef struct packed {
      logic [TRIM_DEPTH-1:0][DATA_W-1:0] words;
      logic [DATA_W-1:0]                 rdata;
   } mem_state_t;

   localparam mem_state_t MEM_RST = '{words: TRIM_RST, rdata: 16'h0000};

   mem_state_t mem_reg;
   mem_state_t mem_next;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      mem_next = mem_reg;
      // Reserved bits stay at zero, so writes go through a mask
      if (bus.wr) begin
         mem_next.words[bus.idx] = (bus.wdata & TRIM_WR_MASK[bus.idx]) |
                                   (mem_reg.words[bus.idx] & ~TRIM_WR_MASK[bus.idx]);
      end
      if (bus.rd) begin
         mem_next.rdata = mem_reg.words[bus.idx];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_reg <= MEM_RST;
      end else begin
         mem_reg <= mem_next;
      end
   end

   assign bus.rdata = mem_reg.rdata;
endmodule
`default_nettype wire

// ==== core/adc_status_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_status_regs #(
   parameter logic [7:0] REVISION_CODE = 8'h5A   // Arbitrary value
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [adc_regs_pkg::ADDR_W-1:0] addr,
   input  wire logic [adc_regs_pkg::DATA_W-1:0] wr_data,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic      [adc_regs_pkg::DATA_W-1:0] rd_data,
   input  wire logic                        lock_state,
   input  wire logic                        realign_pulse,
   input  wire logic                        map_fault_pulse,
   input  wire logic                        rx_crc_error_pulse,
   input  wire logic [adc_regs_pkg::NUM_CH-1:0] sample_ready_pulse,
   input  wire logic [adc_regs_pkg::NUM_CH-1:0] sample_taken,
   input  wire logic [adc_regs_pkg::DATA_W-1:0] map_checksum_in,
   output logic      [adc_regs_pkg::DATA_W-1:0] config_word,
   output logic                             irq
);
   import adc_regs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [DATA_W-1:0] mode;
      logic              reset_flag;
      logic              lock;
      logic              realign;
      logic              map_fault;
      logic              rx_err;
      logic [NUM_CH-1:0] ready;
      logic [IRQ_W-1:0]  irq_st;
      logic [IRQ_W-1:0]  irq_en;
      logic [DATA_W-1:0] rdat;
      logic              trim_sel;
   } regs_state_t;

   localparam regs_state_t REGS_RST = '{
      mode:       MODE_RST,
      reset_flag: MODE_RST[BIT_RESET_FLAG],
      lock:       1'b0,
      realign:    1'b0,
      map_fault:  1'b0,
      rx_err:     1'b0,
      ready:      4'h0,
      irq_st:     7'h00,
      irq_en:     7'h00,
      rdat:       16'h0000,
      trim_sel:   1'b0
   };

   regs_state_t state_reg;
   regs_state_t state_next;

   logic [DATA_W-1:0] ident_word;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] mode_word;
   logic [NUM_CH-1:0] ready_next;
   logic [IRQ_W-1:0]  irq_events;
   logic [IRQ_W-1:0]  irq_clear;
   logic [ADDR_W-1:0] trim_offset;
   logic              in_trim;
   logic              rd_status;

   trim_mem_if trim_bus ();

   ////////////////////////////////////////////////////////////////////////
   // Read views
   assign ident_word = {IDENT_TOP_NIBBLE, CHANNEL_COUNT_FIELD, REVISION_CODE};

   always_comb begin
      status_word                 = 16'h0000;
      status_word[BIT_LOCK]       = state_reg.lock;
      status_word[BIT_REALIGN]    = state_reg.realign;
      status_word[BIT_MAP_FAULT]  = state_reg.map_fault;
      status_word[BIT_RX_CRC_ERR] = state_reg.rx_err;
      status_word[BIT_CRC_TYPE]   = state_reg.mode[BIT_CRC_TYPE];
      status_word[BIT_RESET_FLAG] = state_reg.reset_flag;
      status_word[WSIZE_MSB:WSIZE_LSB] = state_reg.mode[WSIZE_MSB:WSIZE_LSB];
      status_word[NUM_CH-1:0]     = state_reg.ready;
   end

   // Mode bit 10 is stored but never read out; it reads back the flag
   always_comb begin
      mode_word                 = state_reg.mode;
      mode_word[BIT_RESET_FLAG] = state_reg.reset_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel new-data flags; a fresh sample beats a read-out
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ready
         assign ready_next[ch] = sample_ready_pulse[ch] |
                                 (state_reg.ready[ch] & ~sample_taken[ch]);
      end
   endgenerate

   assign irq_events = {sample_ready_pulse, rx_crc_error_pulse, map_fault_pulse, realign_pulse};
   assign irq_clear  = (wr_en && addr == OFF_IRQ_CLEAR) ? wr_data[IRQ_W-1:0] : 7'h00;
   assign rd_status  = rd_en && addr == OFF_STATUS;

   assign trim_offset = addr - OFF_CH2_GAIN_HI;
   assign in_trim     = (addr >= OFF_CH2_GAIN_HI) && (addr <= OFF_CH3_GAIN_LO);

   assign trim_bus.wr    = wr_en && in_trim;
   assign trim_bus.rd    = rd_en && in_trim;
   assign trim_bus.idx   = trim_offset[TRIM_IDX_W-1:0];
   assign trim_bus.wdata = wr_data;

   trim_mem u_trim_mem (
      .clk (clk),
      .rst (rst),
      .bus (trim_bus.store)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next          = state_reg;
      state_next.lock     = lock_state;
      state_next.ready    = ready_next;
      state_next.rdat     = 16'h0000;
      state_next.trim_sel = 1'b0;

      // Sticky event flags clear on a status read; a same-cycle event wins
      state_next.realign   = realign_pulse | (state_reg.realign & ~rd_status);
      state_next.map_fault = map_fault_pulse | (state_reg.map_fault & ~rd_status);
      state_next.rx_err    = rx_crc_error_pulse | (state_reg.rx_err & ~rd_status);

      state_next.irq_st = irq_events | (state_reg.irq_st & ~irq_clear);

      // Writes to identity and status fall through the decode untouched
      if (wr_en) begin
         if (addr == OFF_MODE) begin
            state_next.mode = wr_data;
            if (!wr_data[BIT_RESET_FLAG]) begin
               state_next.reset_flag = 1'b0;
            end
         end else if (addr == OFF_IRQ_ENABLE) begin
            state_next.irq_en = wr_data[IRQ_W-1:0];
         end
      end

      if (rd_en) begin
         if (addr == OFF_IDENT) begin
            state_next.rdat = ident_word;
         end else if (addr == OFF_STATUS) begin
            state_next.rdat = status_word;
         end else if (addr == OFF_MODE) begin
            state_next.rdat = mode_word;
         end else if (in_trim) begin
            state_next.trim_sel = 1'b1;
         end else if (addr == OFF_MAP_CHECKSUM) begin
            state_next.rdat = map_checksum_in;
         end else if (addr == OFF_IRQ_STATUS) begin
            state_next.rdat = {9'h000, state_reg.irq_st};
         end else if (addr == OFF_IRQ_ENABLE) begin
            state_next.rdat = {9'h000, state_reg.irq_en};
         end else begin
            state_next.rdat = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= REGS_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Both sources are flops; the select only picks which one
   assign rd_data     = state_reg.trim_sel ? trim_bus.rdata : state_reg.rdat;
   assign config_word = mode_word;
   assign irq         = |(state_reg.irq_st & state_reg.irq_en);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_mode_write;
      wr_en && addr == OFF_MODE;
   endsequence

   sequence s_status_read;
      rd_en && addr == OFF_STATUS;
   endsequence

   sequence s_ident_read;
      rd_en && addr == OFF_IDENT;
   endsequence

   property p_reset_value;
      @(posedge clk) rst |=> status_word == STATUS_RST;
   endproperty

   a_status_reset_value: assert property (disable iff (1'b0) p_reset_value)
      else $error("status word not 0500h after reset");

   a_ident_channel_count: assert property (s_ident_read |=>
      rd_data[15:8] == {IDENT_TOP_NIBBLE, CHANNEL_COUNT_FIELD})
      else $error("identity upper byte wrong");

   // The flop sits in reset one cycle after the pin was sampled
   a_lock_follows_pin: assert property (!$past(rst) |-> status_word[BIT_LOCK] == $past(lock_state))
      else $error("lock bit does not follow lock input");

   a_realign_sticky: assert property (realign_pulse |=> status_word[BIT_REALIGN])
      else $error("realign flag not set");

   a_status_read_clears: assert property ((s_status_read ##0 !realign_pulse) |=>
      !status_word[BIT_REALIGN]) else $error("realign flag not cleared by status read");

   a_fault_flags_set: assert property ((map_fault_pulse && rx_crc_error_pulse) |=>
      status_word[BIT_MAP_FAULT] && status_word[BIT_RX_CRC_ERR])
      else $error("checksum fault flags not set");

   a_read_clear_order: assert property ((s_status_read and (!map_fault_pulse && !rx_crc_error_pulse))
      |=> !status_word[BIT_MAP_FAULT] && !status_word[BIT_RX_CRC_ERR])
      else $error("checksum flags not cleared by status read");

   a_type_mirror: assert property (s_mode_write |=>
      status_word[BIT_CRC_TYPE] == $past(wr_data[BIT_CRC_TYPE]))
      else $error("checksum type does not mirror mode");

   a_wsize_mirror: assert property (s_mode_write |=>
      status_word[WSIZE_MSB:WSIZE_LSB] == $past(wr_data[WSIZE_MSB:WSIZE_LSB]))
      else $error("word size does not mirror mode");

   a_reset_flag_clear: assert property ((s_mode_write and !wr_data[BIT_RESET_FLAG]) |=>
      !status_word[BIT_RESET_FLAG] [*2])
      else $error("reset flag not cleared by mode write");

   a_reserved_zero: assert property (status_word[7:4] == 4'h0)
      else $error("reserved status bits not zero");

   a_status_readback: assert property (s_status_read |=> rd_data == $past(status_word))
      else $error("status read data wrong");

   a_ro_write_ignored: assert property ((wr_en && (addr == OFF_IDENT || addr == OFF_STATUS))
      |=> config_word == $past(config_word))
      else $error("write to read-only register changed state");

   a_ready_cleared: assert property ((sample_taken[0] && !sample_ready_pulse[0]) |=>
      !status_word[0])
      else $error("new-data flag not cleared by read-out");

   a_ready_set: assert property (sample_ready_pulse[NUM_CH-1] |=> status_word[NUM_CH-1])
      else $error("new-data flag not set");

   a_irq_level: assert property ((realign_pulse && state_reg.irq_en[IRQ_REALIGN]) |=> irq)
      else $error("enabled event did not raise interrupt");

endmodule
`default_nettype wire

// ==== verification/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic                             clk,
   input  wire logic [adc_regs_pkg::DATA_W-1:0]  rd_data,
   output var logic  [adc_regs_pkg::ADDR_W-1:0]  addr,
   output var logic  [adc_regs_pkg::DATA_W-1:0]  wr_data,
   output var logic                              wr_en,
   output var logic                              rd_en
);
   import adc_regs_pkg::*;

   initial begin
      addr    = '0;
      wr_data = '0;
      wr_en   = 1'b0;
      rd_en   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle bus shows inverted values, so stale data never looks valid
   task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
      addr    <= ~a;
      wr_data <= ~d;
   endtask

   task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      addr  <= ~a;
      #1;
      d = rd_data;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reset flag cleared by mode write with bit 10 low
   task automatic clear_reset_flag(input logic [DATA_W-1:0] mode);
      write_word(OFF_MODE, mode & 16'hFBFF);
   endtask

   // Low byte dropped: revision dependent
   task automatic read_id_upper(output logic [7:0] upper);
      logic [DATA_W-1:0] w;
      read_word(OFF_IDENT, w);
      upper = w[15:8];
   endtask
endmodule
`default_nettype wire

// ==== verification/adc_status_regs_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_status_regs_tb_top;
   import adc_regs_pkg::*;

   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic              wr_en;
   logic              rd_en;
   logic [DATA_W-1:0] rd_data;
   logic              lock_state = 1'b0;
   logic              realign_pulse = 1'b0;
   logic              map_fault_pulse = 1'b0;
   logic              rx_crc_error_pulse = 1'b0;
   logic [NUM_CH-1:0] sample_ready_pulse = '0;
   logic [NUM_CH-1:0] sample_taken = '0;
   logic [DATA_W-1:0] map_checksum_in = '0;
   logic [DATA_W-1:0] config_word;
   logic              irq;
   logic [31:0]       seed = 32'd74788;
   int                errors = 0;
   int                total_checks = 0;

   always #5 clk = ~clk;

   adc_status_regs adc_status_regs_inst (
      .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .lock_state(lock_state), .realign_pulse(realign_pulse),
      .map_fault_pulse(map_fault_pulse), .rx_crc_error_pulse(rx_crc_error_pulse),
      .sample_ready_pulse(sample_ready_pulse), .sample_taken(sample_taken),
      .map_checksum_in(map_checksum_in), .config_word(config_word), .irq(irq));

   host_model host_model_inst (
      .clk(clk), .rd_data(rd_data), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] st_exp(input logic lk, input logic ct, input logic rf,
                                          input logic [1:0] ws, input logic [3:0] rdy);
      return {lk, 3'b000, ct, rf, ws, 4'h0, rdy};
   endfunction

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] expv);
      total_checks++;
      if (seen !== expv) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task automatic fire(input logic [2:0] ev, input logic [3:0] rdy, input logic [3:0] tk);
      @(posedge clk);
      {realign_pulse, map_fault_pulse, rx_crc_error_pulse} <= ev;
      sample_ready_pulse <= rdy;
      sample_taken       <= tk;
      @(posedge clk);
      {realign_pulse, map_fault_pulse, rx_crc_error_pulse} <= 3'b000;
      sample_ready_pulse <= '0;
      sample_taken       <= '0;
   endtask

   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Whole run is under a thousand cycles
   initial begin
      #100000;
      errors++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [DATA_W-1:0] v;
      logic [DATA_W-1:0] m;
      logic [31:0]       r;
      logic [7:0]        up;
      logic [3:0]        rdy;
      logic [3:0]        p;
      logic              ct;
      logic [1:0]        ws;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      host_model_inst.read_word(OFF_STATUS, v);
      check(v, st_exp(1'b0, 1'b0, 1'b1, 2'b01, 4'h0));
      check(config_word, 16'h0510);
      for (int i = 0; i < 7; i++) begin
         host_model_inst.read_word(OFF_CH2_GAIN_HI + 6'(i), v);
         check(v, ((i == 0) || (i == 5)) ? 16'h8000 : 16'h0000);
      end
      host_model_inst.read_word(OFF_SPARE, v);
      check(v, 16'h0000);
      // Writes to read-only words must be ignored
      r = next_rand();
      host_model_inst.write_word(OFF_IDENT, r[15:0]);
      host_model_inst.write_word(OFF_STATUS, r[31:16]);
      host_model_inst.read_id_upper(up);
      check({8'h00, up}, 16'h0044);
      host_model_inst.read_word(OFF_STATUS, v);
      check(v, st_exp(1'b0, 1'b0, 1'b1, 2'b01, 4'h0));
      lock_state <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         fire(3'b100 >> k, 4'h0, 4'h0);
         host_model_inst.read_word(OFF_STATUS, v);
         check(v, st_exp(1'b1, 1'b0, 1'b1, 2'b01, 4'h0) | {1'b0, 3'b100 >> k, 12'h000});
      end
      fire(3'b111, 4'h0, 4'h0);
      host_model_inst.read_word(OFF_STATUS, v);
      check(v & 16'h7000, 16'h7000);
      // Every polynomial and word size code
      for (int k = 0; k < 8; k++) begin
         r  = next_rand();
         ct = k[2];
         ws = k[1:0];
         m  = {r[15:12], ct, 1'b1, ws, r[7:0]};
         host_model_inst.write_word(OFF_MODE, m);
         #1;
         check(config_word, m);
         host_model_inst.read_word(OFF_STATUS, v);
         check(v, st_exp(1'b1, ct, 1'b1, ws, 4'h0));
      end
      host_model_inst.clear_reset_flag(m);
      host_model_inst.read_word(OFF_STATUS, v);
      check(v, st_exp(1'b1, ct, 1'b0, ws, 4'h0));
      rdy = 4'h0;
      for (int k = 0; k < 4; k++) begin
         r   = next_rand();
         p   = r[3:0] | 4'h1 << k;
         rdy = rdy | p;
         fire(3'b000, p, 4'h0);
         host_model_inst.read_word(OFF_STATUS, v);
         check(v, st_exp(1'b1, ct, 1'b0, ws, rdy));
         rdy = rdy & ~r[7:4];
         fire(3'b000, 4'h0, r[7:4]);
         host_model_inst.read_word(OFF_STATUS, v);
         check(v, st_exp(1'b1, ct, 1'b0, ws, rdy));
      end
      r = next_rand();
      map_checksum_in <= r[15:0];
      host_model_inst.read_word(OFF_MAP_CHECKSUM, v);
      check(v, r[15:0]);
      // Interrupt: masked, then enabled, then cleared
      host_model_inst.write_word(OFF_IRQ_ENABLE, 16'h0000);
      host_model_inst.write_word(OFF_IRQ_CLEAR, 16'h007F);
      fire(3'b100, 4'h0, 4'h0);
      settle();
      check({15'h0000, irq}, 16'h0000);
      host_model_inst.read_word(OFF_IRQ_STATUS, v);
      check(v & 16'h0001, 16'h0001);
      host_model_inst.write_word(OFF_IRQ_ENABLE, 16'h0001);
      settle();
      check({15'h0000, irq}, 16'h0001);
      host_model_inst.write_word(OFF_IRQ_CLEAR, 16'h0001);
      settle();
      check({15'h0000, irq}, 16'h0000);
      // Event while the mask is already open
      fire(3'b100, 4'h0, 4'h0);
      settle();
      check({15'h0000, irq}, 16'h0001);
      host_model_inst.write_word(OFF_CH3_GAIN_HI, r[31:16]);
      host_model_inst.read_word(OFF_CH3_GAIN_HI, v);
      check(v, r[31:16]);
      // Second reset in mid-run brings back every reset value
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      host_model_inst.read_word(OFF_STATUS, v);
      check(v, st_exp(1'b1, 1'b0, 1'b1, 2'b01, 4'h0));
      check(config_word, MODE_RST);
      check({15'h0000, irq}, 16'h0000);
      host_model_inst.read_word(OFF_CH3_GAIN_HI, v);
      check(v, 16'h8000);
      print_verdict();
   end
endmodule
`default_nettype wire
